// File: pd_source_pin_signalling.sv
// Summary of operation
// [R1] While reset is high both CC pins are left floating with no termination or drive.
// [R2] Reset high reinitialises all state; the stored startup configuration is reloaded on the first clock edge after release.
// [R3] Orientation output floats for CC1 attachment and pulls low for CC2 attachment.
// [R4] The detected orientation is also presented in a host-readable status bit.
// [R5] Source power enable pulls low only with a sink attached and bus voltage valid.
// [R6] The present level of the power enable pin is mirrored into a host status bit.
// [R7] Supply undervoltage and overvoltage lockouts, each separately enabled, also gate power enable.
// [R8] The address strap is sampled once after startup and held as address bit 0 until next reset.
// [R9] With select 11b, general_io_0 pulls low while the second profile is selected.
// [R10] With select 11b, general_io_1 pulls low while the third profile is selected.
// [R11] With group select 11b, io_2 flags profile four, io_3 profile five and io_4 sink attachment.
// [R12] Profile flags clear on reset so every profile output starts released.
// [R13] With a valid connection and VCONN switches enabled, VCONN goes to the unused CC pin.
// [R14] The interrupt line pulls low to request attention and floats otherwise.
// [R15] The external discharge control output switches the external discharge path.
// [R16] Open-drain pins are only pulled low or released, never driven high.
// [R17] The board supplies pull-ups so that released open-drain lines read high.
module pd_source_pin_signalling (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire pd_pin_pkg::core_status_t core_status,
  input wire pd_pin_pkg::startup_cfg_t stored_cfg,
  input wire logic variable_voltage_addr_strap,
  output pd_pin_pkg::od_pin_t orientation_select,
  output pd_pin_pkg::od_pin_t source_power_enable_n,
  output pd_pin_pkg::od_pin_t interrupt_request_n,
  output pd_pin_pkg::od_pin_t [pd_pin_pkg::GPO_N-1:0] general_io,
  output logic external_discharge_ctl,
  output logic cc_termination_en,
  output logic vconn_to_cc1,
  output logic vconn_to_cc2,
  output logic i2c_addr_bit0,
  output pd_pin_pkg::host_status_t host_status
);
  import pd_pin_pkg::*;

  typedef enum logic [1:0] {
    ST_RESET = 2'h0,
    ST_SAMPLE = 2'h1,
    ST_RUN = 2'h3
  } phase_t;

  phase_t phase_q, phase_d;
  startup_cfg_t cfg_q, cfg_d;
  logic addr0_q, addr0_d;
  logic run;
  logic attached;
  logic vconn_on;
  logic uvlo_ok;
  logic ovlo_ok;
  logic supply_ok;
  logic gpo0_profile_mode;
  logic gpo1_profile_mode;
  logic group_profile_mode;
  logic [3:0] profile_select_flag;

  // Registered pin state
  logic term_q, term_d;
  logic orient_q, orient_d;
  logic vc1_q, vc1_d;
  logic vc2_q, vc2_d;
  logic pwr_en_q, pwr_en_d;
  logic irq_q, irq_d;
  logic disch_q, disch_d;
  logic [GPO_N-1:0] gpo_q, gpo_d;
  host_status_t status_q, status_d;

  // Startup sequence: configuration reload, then one strap sample, then run
  always_comb begin
    phase_d = phase_q;
    cfg_d = cfg_q;
    addr0_d = addr0_q;
    case (phase_q)
      ST_RESET: begin
        // Snapshot of the stored startup configuration
        cfg_d = stored_cfg; // R2
        phase_d = ST_SAMPLE;
      end
      ST_SAMPLE: begin
        // Strap is read once here and ignored until the next reset
        addr0_d = variable_voltage_addr_strap; // R8
        phase_d = ST_RUN;
      end
      ST_RUN: begin
        phase_d = ST_RUN;
      end
      default: begin
        phase_d = ST_RESET;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      phase_q <= ST_RESET; // R2
      cfg_q.uvlo_check_en <= 1'b0;
      cfg_q.ovlo_check_en <= 1'b0;
      cfg_q.gpo0_function_select <= GPO_SEL_RESET;
      cfg_q.gpo1_function_select <= GPO_SEL_RESET;
      cfg_q.gpo_group_function_select <= GPO_SEL_RESET;
      addr0_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      cfg_q <= cfg_d;
      addr0_q <= addr0_d;
    end
  end

  // Pin logic follows the core only once startup sampling is done
  assign run = (phase_q == ST_RUN);
  assign attached = run && core_status.sink_attached;
  assign vconn_on = attached && core_status.vconn_switch_en;

  // Configuration channel termination, orientation and VCONN routing
  always_comb begin
    term_d = run; // R1
    orient_d = attached && core_status.on_cc2; // R3
    // VCONN goes to the CC pin that the cable does not use
    vc1_d = vconn_on && core_status.on_cc2; // R13
    vc2_d = vconn_on && !core_status.on_cc2; // R13
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      term_q <= 1'b0; // R1
      orient_q <= 1'b0;
      vc1_q <= 1'b0;
      vc2_q <= 1'b0;
    end else begin
      term_q <= term_d;
      orient_q <= orient_d;
      vc1_q <= vc1_d;
      vc2_q <= vc2_d;
    end
  end

  // Power path, discharge and interrupt request; a disabled lockout is ignored
  always_comb begin
    uvlo_ok = !cfg_q.uvlo_check_en || core_status.supply_above_uvlo; // R7
    ovlo_ok = !cfg_q.ovlo_check_en || core_status.supply_below_ovlo; // R7
    supply_ok = uvlo_ok && ovlo_ok; // R7
    pwr_en_d = attached && core_status.bus_voltage_valid && supply_ok; // R5 R7
    irq_d = run && core_status.irq_pending; // R14
    disch_d = run && core_status.discharge_req; // R15
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pwr_en_q <= 1'b0;
      irq_q <= 1'b0;
      disch_q <= 1'b0;
    end else begin
      pwr_en_q <= pwr_en_d;
      irq_q <= irq_d;
      disch_q <= disch_d;
    end
  end

  // Profile flags stay clear outside the run phase; other selects leave the pins released
  always_comb begin
    gpo0_profile_mode = (cfg_q.gpo0_function_select == GPO_SEL_PROFILE); // R9
    gpo1_profile_mode = (cfg_q.gpo1_function_select == GPO_SEL_PROFILE); // R10
    group_profile_mode = (cfg_q.gpo_group_function_select == GPO_SEL_PROFILE); // R11
    profile_select_flag = '0; // R12
    if (run) begin
      profile_select_flag[0] = (core_status.profile_sel == PROFILE_2);
      profile_select_flag[1] = (core_status.profile_sel == PROFILE_3);
      profile_select_flag[2] = (core_status.profile_sel == PROFILE_4);
      profile_select_flag[3] = (core_status.profile_sel == PROFILE_5);
    end
    gpo_d[0] = gpo0_profile_mode && profile_select_flag[0]; // R9
    gpo_d[1] = gpo1_profile_mode && profile_select_flag[1]; // R10
    gpo_d[2] = group_profile_mode && profile_select_flag[2]; // R11
    gpo_d[3] = group_profile_mode && profile_select_flag[3]; // R11
    gpo_d[4] = group_profile_mode && attached; // R11
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      gpo_q <= '0; // R12
    end else begin
      gpo_q <= gpo_d;
    end
  end

  // Host status holds the power enable and general IO pad levels as they read with the board pull-ups; the orientation bit is high for CC2
  always_comb begin
    status_d.orientation_cc2 = orient_d; // R4
    status_d.power_enable_level = !pwr_en_d; // R6
    status_d.gpo_level = ~gpo_d;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      status_q.orientation_cc2 <= 1'b0;
      status_q.power_enable_level <= 1'b1;
      status_q.gpo_level <= '1;
    end else begin
      status_q <= status_d;
    end
  end

  // Open-drain pads carry a constant low data value
  always_comb begin
    orientation_select = '{out: 1'b0, oe: orient_q}; // R16
    source_power_enable_n = '{out: 1'b0, oe: pwr_en_q}; // R16
    interrupt_request_n = '{out: 1'b0, oe: irq_q}; // R16
    for (int i = 0; i < GPO_N; i++) begin
      general_io[i] = '{out: 1'b0, oe: gpo_q[i]}; // R16
    end
  end

  // Plain level outputs
  assign external_discharge_ctl = disch_q;
  assign cc_termination_en = term_q;
  assign vconn_to_cc1 = vc1_q;
  assign vconn_to_cc2 = vc2_q;
  assign i2c_addr_bit0 = addr0_q;
  assign host_status = status_q; // R4 R6

endmodule : pd_source_pin_signalling

// File: pd_pin_pkg.sv
package pd_pin_pkg;

  localparam logic [1:0] GPO_SEL_PROFILE = 2'h3;
  localparam logic [1:0] GPO_SEL_RESET = 2'h0;
  localparam int PROFILE_W = 3;
  localparam logic [2:0] PROFILE_NONE = 3'h0;
  localparam logic [2:0] PROFILE_2 = 3'h1;
  localparam logic [2:0] PROFILE_3 = 3'h2;
  localparam logic [2:0] PROFILE_4 = 3'h3;
  localparam logic [2:0] PROFILE_5 = 3'h4;
  localparam int GPO_N = 5;

  // Core-side inputs from connection, monitoring and policy logic
  typedef struct packed {
    logic sink_attached;
    logic on_cc2;
    logic bus_voltage_valid;
    logic supply_above_uvlo;
    logic supply_below_ovlo;
    logic vconn_switch_en;
    logic discharge_req;
    logic irq_pending;
    logic [PROFILE_W-1:0] profile_sel;
  } core_status_t;

  // Lockout checks and output function selects
  typedef struct packed {
    logic uvlo_check_en;
    logic ovlo_check_en;
    logic [1:0] gpo0_function_select;
    logic [1:0] gpo1_function_select;
    logic [1:0] gpo_group_function_select;
  } startup_cfg_t;

  // Two-state drive: oe high pulls pad low, data is always 0
  typedef struct packed {
    logic out;
    logic oe;
  } od_pin_t;

  typedef struct packed {
    logic orientation_cc2;
    logic power_enable_level;
    logic [GPO_N-1:0] gpo_level;
  } host_status_t;

endpackage : pd_pin_pkg

// File: pd_pin_board.sv
module pd_pin_board
  import pd_pin_pkg::*;
(
  input wire pd_pin_pkg::od_pin_t [pd_pin_pkg::GPO_N-1:0] general_io,
  output logic [pd_pin_pkg::GPO_N-1:0] gpo_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pull-ups: a released line reads high
  always_comb for (int i = 0; i < GPO_N; i++) gpo_pin[i] = general_io[i].oe ? general_io[i].out : 1'b1;
endmodule : pd_pin_board

// File: pd_source_pin_signalling_props.sv
module pd_pin_props
  import pd_pin_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire pd_pin_pkg::core_status_t core_status,
  input wire pd_pin_pkg::od_pin_t orientation_select,
  input wire pd_pin_pkg::od_pin_t source_power_enable_n,
  input wire pd_pin_pkg::od_pin_t interrupt_request_n,
  input wire pd_pin_pkg::od_pin_t [pd_pin_pkg::GPO_N-1:0] general_io,
  input wire logic external_discharge_ctl,
  input wire logic cc_termination_en,
  input wire logic vconn_to_cc1,
  input wire logic vconn_to_cc2,
  input wire pd_pin_pkg::host_status_t host_status
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] up_q;
  logic supply_good;
  logic live;
  core_status_t c_q;
  // Outputs track inputs from the third edge after release
  always_ff @(posedge ref_clk) begin
    up_q <= sys_rst ? 2'h0 : (up_q == 2'h3 ? up_q : up_q + 2'h1);
    c_q <= core_status;
  end
  assign live = up_q == 2'h3;
  assign supply_good = c_q.supply_above_uvlo && c_q.supply_below_ovlo;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  rst_quiet_a: assert property ($fell(sys_rst) |-> !cc_termination_en && general_io == '0)
    else $error("outputs active after reset");
  orient_pin_a: assert property (live && c_q.sink_attached |-> orientation_select.oe == c_q.on_cc2)
    else $error("orientation wrong");
  pwr_off_a: assert property (live && !(c_q.sink_attached && c_q.bus_voltage_valid) |-> !source_power_enable_n.oe)
    else $error("power enabled early");
  pwr_on_a: assert property (live && c_q.sink_attached && c_q.bus_voltage_valid && supply_good |->
    source_power_enable_n.oe) else $error("power not enabled");
  pwr_mirror_a: assert property (live |-> host_status.power_enable_level == !source_power_enable_n.oe)
    else $error("mirror wrong");
  orient_mirror_a: assert property (host_status.orientation_cc2 == orientation_select.oe)
    else $error("orientation status wrong");
  vconn_route_a: assert property (live && c_q.sink_attached && c_q.vconn_switch_en |->
    vconn_to_cc1 == c_q.on_cc2 && vconn_to_cc2 == !c_q.on_cc2) else $error("vconn wrong");
  irq_line_a: assert property (live |-> interrupt_request_n.oe == c_q.irq_pending) else $error("irq wrong");
  disch_ctl_a: assert property (live |-> external_discharge_ctl == c_q.discharge_req) else $error("disch wrong");
  cover property (live && orientation_select.oe);
  cover property (live && source_power_enable_n.oe);
  cover property (live && interrupt_request_n.oe);
  cover property (live && vconn_to_cc1);
endmodule : pd_pin_props
bind pd_source_pin_signalling pd_pin_props i_props (.ref_clk, .sys_rst, .core_status, .orientation_select,
  .source_power_enable_n, .interrupt_request_n, .general_io, .external_discharge_ctl, .cc_termination_en,
  .vconn_to_cc1, .vconn_to_cc2, .host_status);

// File: pd_source_pin_signalling_tb_top.sv
module pd_source_pin_signalling_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import pd_pin_pkg::*;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic strap = 1'b1;
  core_status_t cs = '0;
  startup_cfg_t cfg = 8'hff;
  od_pin_t ori, pwr, irq;
  od_pin_t [GPO_N-1:0] gio;
  logic disch, term, v1, v2, addr;
  host_status_t hs;
  logic [GPO_N-1:0] pin;
  int failures = 0;
  int n_checks = 0;
  always #10 ref_clk = ~ref_clk;
  pd_source_pin_signalling i_dut (.ref_clk, .sys_rst, .core_status(cs), .stored_cfg(cfg),
    .variable_voltage_addr_strap(strap), .orientation_select(ori), .source_power_enable_n(pwr),
    .interrupt_request_n(irq), .general_io(gio), .external_discharge_ctl(disch), .cc_termination_en(term),
    .vconn_to_cc1(v1), .vconn_to_cc2(v2), .i2c_addr_bit0(addr), .host_status(hs));
  pd_pin_board i_board (.general_io(gio), .gpo_pin(pin));
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task end_sim;
    if (failures == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim
  task cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : cyc
  task t_reset(input logic s);
    sys_rst = 1'b1;
    strap = s;
    cyc(12);
    chk({term, gio, hs.gpo_level}, 16'h001f);
    sys_rst = 1'b0;
    cyc(3);
    chk(addr, s);
  endtask : t_reset
  task t_attach(input logic cc2);
    cs = {1'b1, cc2, 4'hf, 2'h0, 3'h0};
    cyc(1);
    chk({ori.oe, hs.orientation_cc2, pwr.oe, hs.power_enable_level, v1, v2}, {cc2, cc2, 2'b10, cc2, !cc2});
  endtask : t_attach
  task t_lock_events;
    for (int i = 0; i < 3; i++) begin
      cs = {1'b1, i != 2, 1'b1, i[0], !i[0], 6'h18};
      cyc(1);
      chk({pwr.oe, hs.power_enable_level, irq.oe, disch}, 4'h7);
    end
  endtask : t_lock_events
  task t_gpo(input logic on);
    logic [GPO_N-1:0] exp;
    for (int p = 0; p < 5; p++) begin
      cs = {p[0], 7'h0, p[2:0]};
      exp = on ? ~{p[0], p == 4, p == 3, p == 2, p == 1} : 5'h1f;
      cyc(1);
      chk({pin, hs.gpo_level}, {exp, exp});
    end
  endtask : t_gpo
  // Late changes to the stored configuration and the strap must not take effect
  task t_refuse;
    cfg = 8'h40;
    strap = 1'b0;
    cyc(2);
    chk(addr, 1'b1);
    t_gpo(1'b1);
  endtask : t_refuse
  // Only the overvoltage lockout is enabled after the second reset
  task t_lock_sel;
    cs = {3'h5, 2'h1, 6'h00};
    cyc(1);
    chk({pwr.oe, hs.power_enable_level}, 2'b10);
    cs = {3'h5, 2'h2, 6'h00};
    cyc(1);
    chk({pwr.oe, hs.power_enable_level}, 2'b01);
  endtask : t_lock_sel
  initial begin
    t_reset(1'b1);
    t_attach(1'b1);
    t_attach(1'b0);
    t_lock_events;
    t_gpo(1'b1);
    t_refuse;
    t_reset(1'b0);
    t_gpo(1'b0);
    t_lock_sel;
    end_sim;
  end
  initial begin
    #20000;
    failures++;
    end_sim;
  end
endmodule : pd_source_pin_signalling_tb_top
